// ===== dv/udt_pin_model.sv
// pin-side model: external event source, direction level and the shared count pin
`timescale 1ns/100ps
module udt_pin_model (
    input  wire logic clock,
    input  wire logic pin_o,
    input  wire logic pin_oe_b,
    output logic      dir_pin,
    output logic      pin_i
);
    logic ext_drive;

    // a released pin rests high through its pull-up
    initial begin
        ext_drive = 1'b1;
        dir_pin   = 1'b1;
    end

    // the device owns the wire while its enable is low
    assign pin_i = pin_oe_b ? ext_drive : pin_o;

    // slow events: each low and high phase lasts longer than the input synchroniser
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            ext_drive <= 1'b0;
            repeat (5) @(posedge clock);
            ext_drive <= 1'b1;
            repeat (5) @(posedge clock);
        end
    endtask

    // level held long enough to pass the three-stage synchroniser
    task automatic set_dir(input logic v);
        @(posedge clock);
        dir_pin <= v;
        repeat (4) @(posedge clock);
    endtask
endmodule // udt_pin_model

// ===== dv/updown_reload_timer_clockout_tb_top.sv
// self-checking bench for the up/down timer over its register bus and pins
`timescale 1ns/100ps
`include "udt_consts.svh"
module updown_reload_timer_clockout_tb_top;
    logic        clock;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dir_pin;
    logic        pin_i;
    logic        pin_o;
    logic        pin_oe_b;
    logic        baud_tick;
    logic        irq;
    logic [31:0] q;
    logic        err;
    int          mismatches;
    int          compares;
    int          baud_seen;
    int          hp;

    udt_timer udt_timer_inst (
        .CLOCK(clock), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DIR_PIN(dir_pin), .CLKOUT_PIN_I(pin_i),
        .CLKOUT_PIN_O(pin_o), .CLKOUT_PIN_OE_B(pin_oe_b), .BAUD_TICK(baud_tick),
        .IRQ(irq)
    );

    udt_pin_model udt_pin_model_inst (
        .clock(clock), .pin_o(pin_o), .pin_oe_b(pin_oe_b), .dir_pin(dir_pin),
        .pin_i(pin_i)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        if (baud_tick === 1'b1) baud_seen++;
    end

    task automatic report_and_stop();
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one transfer; a dead slave is ended by the watchdog, not here
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q[7:0], exp);
    endtask

    // edges until the generated clock changes, started from a fresh change
    task automatic half_period(output int n);
        logic last;
        int   i;
        i    = 0;
        last = pin_o;
        while (pin_o === last && i < 60) begin
            @(posedge clock);
            #1;
            i++;
        end
        last = pin_o;
        n    = 0;
        while (pin_o === last && n < 60) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    initial begin
        #2000000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        mismatches = 0;
        compares = 0;
        baud_seen = 0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk({6'h00, irq, pin_oe_b}, 8'h01);
        rdchk(`UDT_OFS_CTRL, 8'h00);
        rdchk(`UDT_OFS_MODE, 8'h00);
        apb(1'b0, 8'h20, 32'h00000000);
        chk({7'h00, err}, 8'h01);
        chk(q[7:0], 8'h00);
        wr(`UDT_OFS_MODE, 8'hFF);
        rdchk(`UDT_OFS_MODE, 8'h03);
        wr(`UDT_OFS_MODE, 8'h00);
        $display("test reset_map done");

        // one prescaled tick lands between run set and run clear
        wr(`UDT_OFS_CNT_LO, 8'hFF);
        wr(`UDT_OFS_CNT_HI, 8'h00);
        wr(`UDT_OFS_CTRL, 8'h04);
        repeat (16) @(posedge clock);
        wr(`UDT_OFS_CTRL, 8'h00);
        rdchk(`UDT_OFS_CNT_LO, 8'h00);
        rdchk(`UDT_OFS_CNT_HI, 8'h01);
        repeat (30) @(posedge clock);
        rdchk(`UDT_OFS_CNT_LO, 8'h00);
        $display("test timer_prescale done");

        wr(`UDT_OFS_CNT_HI, 8'h00);
        // capture mode: free up-count of pin events
        wr(`UDT_OFS_CTRL, 8'h07);
        udt_pin_model_inst.pulse(3);
        repeat (8) @(posedge clock);
        wr(`UDT_OFS_CTRL, 8'h00);
        rdchk(`UDT_OFS_CNT_LO, 8'h03);
        $display("test event_count done");

        udt_pin_model_inst.set_dir(1'b1);
        wr(`UDT_OFS_MODE, 8'h01);
        wr(`UDT_OFS_RLD_LO, 8'h34);
        wr(`UDT_OFS_RLD_HI, 8'h12);
        wr(`UDT_OFS_CNT_LO, 8'hFF);
        wr(`UDT_OFS_CNT_HI, 8'hFF);
        wr(`UDT_OFS_IRQ_MSK, 8'h00);
        wr(`UDT_OFS_CTRL, 8'h04);
        repeat (16) @(posedge clock);
        rdchk(`UDT_OFS_CTRL, 8'hC4);
        wr(`UDT_OFS_CTRL, 8'h40);
        rdchk(`UDT_OFS_CNT_LO, 8'h34);
        rdchk(`UDT_OFS_CNT_HI, 8'h12);
        rdchk(`UDT_OFS_IRQ_ST, 8'h01);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr(`UDT_OFS_IRQ_MSK, 8'h03);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(`UDT_OFS_IRQ_ST, 8'h01);
        #1;
        chk({7'h00, irq}, 8'h00);
        $display("test count_up done");

        // one step down to the reload value, then underflow; the extra flag flips back
        udt_pin_model_inst.set_dir(1'b0);
        wr(`UDT_OFS_CNT_LO, 8'h35);
        wr(`UDT_OFS_CNT_HI, 8'h12);
        wr(`UDT_OFS_CTRL, 8'h44);
        repeat (28) @(posedge clock);
        rdchk(`UDT_OFS_CTRL, 8'h84);
        wr(`UDT_OFS_CTRL, 8'h00);
        rdchk(`UDT_OFS_CNT_LO, 8'hFF);
        rdchk(`UDT_OFS_CNT_HI, 8'hFF);
        rdchk(`UDT_OFS_IRQ_ST, 8'h01);
        wr(`UDT_OFS_IRQ_ST, 8'h03);
        $display("test count_down done");

        // a falling direction edge with its enable reloads the count even when stopped
        wr(`UDT_OFS_MODE, 8'h00);
        wr(`UDT_OFS_CTRL, 8'h08);
        udt_pin_model_inst.set_dir(1'b1);
        udt_pin_model_inst.set_dir(1'b0);
        rdchk(`UDT_OFS_CTRL, 8'h48);
        rdchk(`UDT_OFS_CNT_LO, 8'h34);
        rdchk(`UDT_OFS_IRQ_ST, 8'h02);
        wr(`UDT_OFS_IRQ_ST, 8'h03);
        wr(`UDT_OFS_CTRL, 8'h00);
        $display("test ext_reload done");

        // reload FFFEh: two fast ticks per overflow, so four clocks per half period
        wr(`UDT_OFS_MODE, 8'h02);
        wr(`UDT_OFS_CTRL, 8'h00);
        wr(`UDT_OFS_RLD_LO, 8'hFE);
        wr(`UDT_OFS_RLD_HI, 8'hFF);
        wr(`UDT_OFS_CNT_LO, 8'hF0);
        wr(`UDT_OFS_CNT_HI, 8'hFF);
        wr(`UDT_OFS_CTRL, 8'h04);
        #1;
        chk({7'h00, pin_oe_b}, 8'h00);
        chk({7'h00, pin_i}, {7'h00, pin_o});
        half_period(hp);
        chk(hp[7:0], 8'h04);
        half_period(hp);
        chk(hp[7:0], 8'h04);
        rdchk(`UDT_OFS_IRQ_ST, 8'h00);
        rdchk(`UDT_OFS_CTRL, 8'h04);
        $display("test clock_out done");

        baud_seen = 0;
        wr(`UDT_OFS_CTRL, 8'h14);
        half_period(hp);
        chk(hp[7:0], 8'h04);
        chk({7'h00, baud_seen > 0}, 8'h01);
        wr(`UDT_OFS_CTRL, 8'h00);
        wr(`UDT_OFS_MODE, 8'h00);
        $display("test baud_with_clock done");
        report_and_stop();
    end
endmodule // updown_reload_timer_clockout_tb_top

// ===== hw/udt_consts.svh
// register offsets, field positions, reset values and divide ratios of the up/down timer
`ifndef UDT_CONSTS_SVH
`define UDT_CONSTS_SVH

`define UDT_OFS_CTRL    8'h00
`define UDT_OFS_MODE    8'h04
`define UDT_OFS_CNT_LO  8'h08
`define UDT_OFS_CNT_HI  8'h0C
`define UDT_OFS_RLD_LO  8'h10
`define UDT_OFS_RLD_HI  8'h14
`define UDT_OFS_IRQ_ST  8'h18
`define UDT_OFS_IRQ_MSK 8'h1C

`define UDT_C_TF   7
`define UDT_C_EXF  6
`define UDT_C_RCLK 5
`define UDT_C_TXCLK 4
`define UDT_C_EXEN 3
`define UDT_C_RUN  2
`define UDT_C_SRC  1
`define UDT_C_CPRL 0

`define UDT_M_DOWN 0
`define UDT_M_OE   1

`define UDT_I_OVF 0
`define UDT_I_EXT 1

`define UDT_RST_CTRL 8'h00
`define UDT_RST_MODE 2'h0
`define UDT_RST_IRQ  2'h0
`define UDT_RST_WORD 16'h0000

`define UDT_CNT_FULL 16'hFFFF
`define UDT_CNT_STEP 16'h0001

`define UDT_DIV_TIMER 12
`define UDT_DIV_FAST  2

`endif

// ===== hw/udt_pkg.sv
// types shared by the up/down timer modules
package udt_pkg;

    typedef enum logic [1:0] {
        UDT_MODE_CAPTURE = 2'b00,
        UDT_MODE_RELOAD  = 2'b01,
        UDT_MODE_BAUD    = 2'b10,
        UDT_MODE_CLKOUT  = 2'b11
    } udt_mode_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } udt_div_state_type;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [1:0]  mode;
        logic [15:0] cnt;
        logic [15:0] rld;
        logic [1:0]  irq_st;
        logic [1:0]  irq_mask;
        logic        clk_out;
        logic        baud;
        logic [2:0]  cnt_sync;
        logic [2:0]  dir_sync;
        logic [31:0] rdata;
    } udt_state_type;

endpackage

// ===== hw/udt_tick_div.sv
// clock divider giving a one-cycle tick every DIV clocks while enabled
`timescale 1ns/100ps
module udt_tick_div #(
    parameter int DIV = 12
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic en,
    output logic      tick
);

    udt_pkg::udt_div_state_type state_ff;
    udt_pkg::udt_div_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        if (!en) begin
            // restart the phase so a stopped timer resumes with a full period
            nxt_state.cnt = 8'h00;
        end else if (state_ff.cnt == 8'(DIV - 1)) begin
            nxt_state.cnt = 8'h00;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tick = state_ff.tick;

endmodule // udt_tick_div

// ===== hw/udt_timer.sv
// up/down auto-reload timer with clock output, APB registers and interrupt
`timescale 1ns/100ps
`include "udt_consts.svh"
// Notes on behaviour
// - count is 16 bits as low and high bytes, low carrying into high
// - source select outside baud and clock-out modes: clear counts clock over 12, set counts external pin events
// - counting advances only while run is set; clear run stops it
// - capture, auto-reload and baud modes chosen by clock selects and capture bit
// - reload mode: down enable clear counts up; set lets direction pin choose
// - up/down with direction high counts up; FFFFh overflow sets flag, interrupts
// - each up overflow outside capture mode loads the reload value into the count; capture wraps to 0000h
// - direction low counts down; underflow when count equals reload value
// - underflow sets overflow flag and loads FFFFh into the count
// - external flag toggles each over/underflow as a 17th bit, no interrupt
// - clock-out mode drives a 50% duty clock
// - clock-out mode advances the count at clock over 2
// - clock-out counts to overflow, reloads, and raises no interrupt
// - output frequency is clock over 4*(65536-reload): one toggle per overflow
// - generated clock leaves on the external count pin
// - baud generation and clock-out may run together sharing one reload value
// - mode register: down enable bit 0, output enable bit 1, reset 0
module udt_timer (
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        DIR_PIN,
    input  wire logic        CLKOUT_PIN_I,
    output logic             CLKOUT_PIN_O,
    output logic             CLKOUT_PIN_OE_B,
    output logic             BAUD_TICK,
    output logic             IRQ
);

    udt_pkg::udt_state_type state_ff;
    udt_pkg::udt_state_type nxt_state;
    udt_pkg::udt_mode_type  mode_sel;

    logic        tick12;
    logic        tick2;
    logic        run;
    logic        fast;
    logic        tick;
    logic        ext_fall;
    logic        dir_fall;
    logic        dir_up;
    logic        updown;
    logic        cnt_full;
    logic        ext_evt;
    logic        addr_hit;
    logic        wr_en;
    logic        wr_cnt;
    logic        wr_ctrl;
    logic        wr_irq;
    logic        set_tf;
    logic        set_exf;
    logic        tog_exf;
    logic [31:0] rd_word;

    udt_tick_div #(
        .DIV (`UDT_DIV_TIMER)
    ) u_div_timer (
        .clock (CLOCK),
        .rst_b (RST_B),
        .en    (run),
        .tick  (tick12)
    );

    udt_tick_div #(
        .DIV (`UDT_DIV_FAST)
    ) u_div_fast (
        .clock (CLOCK),
        .rst_b (RST_B),
        .en    (run),
        .tick  (tick2)
    );

    // mode decode: baud selects win, then clock-out, then capture/reload
    always_comb begin
        if (state_ff.ctrl[`UDT_C_RCLK] || state_ff.ctrl[`UDT_C_TXCLK]) begin
            mode_sel = udt_pkg::UDT_MODE_BAUD;
        end else if (state_ff.mode[`UDT_M_OE]) begin
            mode_sel = udt_pkg::UDT_MODE_CLKOUT;
        end else if (state_ff.ctrl[`UDT_C_CPRL]) begin
            mode_sel = udt_pkg::UDT_MODE_CAPTURE;
        end else begin
            mode_sel = udt_pkg::UDT_MODE_RELOAD;
        end
    end

    // only the second and third sync stages are looked at
    assign ext_fall = state_ff.cnt_sync[2] & ~state_ff.cnt_sync[1];
    assign dir_fall = state_ff.dir_sync[2] & ~state_ff.dir_sync[1];
    assign dir_up   = state_ff.dir_sync[1];

    assign run  = state_ff.ctrl[`UDT_C_RUN];
    assign fast = (mode_sel == udt_pkg::UDT_MODE_BAUD) || (mode_sel == udt_pkg::UDT_MODE_CLKOUT);
    // the pin cannot be both clock out and count input, so fast modes ignore the source bit
    assign tick = !run ? 1'b0 :
                  fast ? tick2 :
                  state_ff.ctrl[`UDT_C_SRC] ? ext_fall : tick12;
    assign updown   = (mode_sel == udt_pkg::UDT_MODE_RELOAD) && state_ff.mode[`UDT_M_DOWN];
    assign cnt_full = (state_ff.cnt == `UDT_CNT_FULL);
    assign ext_evt  = state_ff.ctrl[`UDT_C_EXEN] && dir_fall && !updown
                      && (mode_sel != udt_pkg::UDT_MODE_CLKOUT);

    assign addr_hit = (PADDR == `UDT_OFS_CTRL)   || (PADDR == `UDT_OFS_MODE)
                   || (PADDR == `UDT_OFS_CNT_LO) || (PADDR == `UDT_OFS_CNT_HI)
                   || (PADDR == `UDT_OFS_RLD_LO) || (PADDR == `UDT_OFS_RLD_HI)
                   || (PADDR == `UDT_OFS_IRQ_ST) || (PADDR == `UDT_OFS_IRQ_MSK);
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign wr_cnt  = wr_en && ((PADDR == `UDT_OFS_CNT_LO) || (PADDR == `UDT_OFS_CNT_HI));
    assign wr_ctrl = wr_en && (PADDR == `UDT_OFS_CTRL);
    assign wr_irq  = wr_en && (PADDR == `UDT_OFS_IRQ_ST);

    always_comb begin
        case (PADDR)
            `UDT_OFS_CTRL:    rd_word = {24'h000000, state_ff.ctrl};
            `UDT_OFS_MODE:    rd_word = {30'h0000000, state_ff.mode};
            `UDT_OFS_CNT_LO:  rd_word = {24'h000000, state_ff.cnt[7:0]};
            `UDT_OFS_CNT_HI:  rd_word = {24'h000000, state_ff.cnt[15:8]};
            `UDT_OFS_RLD_LO:  rd_word = {24'h000000, state_ff.rld[7:0]};
            `UDT_OFS_RLD_HI:  rd_word = {24'h000000, state_ff.rld[15:8]};
            `UDT_OFS_IRQ_ST:  rd_word = {30'h0000000, state_ff.irq_st};
            `UDT_OFS_IRQ_MSK: rd_word = {30'h0000000, state_ff.irq_mask};
            default:          rd_word = 32'h00000000;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        set_tf    = 1'b0;
        set_exf   = 1'b0;
        tog_exf   = 1'b0;
        nxt_state.baud     = 1'b0;
        nxt_state.cnt_sync = {state_ff.cnt_sync[1:0], CLKOUT_PIN_I};
        nxt_state.dir_sync = {state_ff.dir_sync[1:0], DIR_PIN};

        if (tick) begin
            case (mode_sel)
                udt_pkg::UDT_MODE_BAUD: begin
                    if (cnt_full) begin
                        nxt_state.cnt  = state_ff.rld;
                        nxt_state.baud = 1'b1;
                        // both functions share the reload value, so rates are tied
                        if (state_ff.mode[`UDT_M_OE]) begin
                            nxt_state.clk_out = ~state_ff.clk_out;
                        end
                    end else begin
                        nxt_state.cnt = state_ff.cnt + `UDT_CNT_STEP;
                    end
                end
                udt_pkg::UDT_MODE_CLKOUT: begin
                    if (cnt_full) begin
                        nxt_state.cnt     = state_ff.rld;
                        nxt_state.clk_out = ~state_ff.clk_out;
                    end else begin
                        nxt_state.cnt = state_ff.cnt + `UDT_CNT_STEP;
                    end
                end
                udt_pkg::UDT_MODE_CAPTURE: begin
                    nxt_state.cnt = state_ff.cnt + `UDT_CNT_STEP;
                    set_tf = cnt_full;
                end
                udt_pkg::UDT_MODE_RELOAD: begin
                    if (updown && !dir_up) begin
                        if (state_ff.cnt == state_ff.rld) begin
                            nxt_state.cnt = `UDT_CNT_FULL;
                            set_tf  = 1'b1;
                            tog_exf = 1'b1;
                        end else begin
                            nxt_state.cnt = state_ff.cnt - `UDT_CNT_STEP;
                        end
                    end else if (cnt_full) begin
                        nxt_state.cnt = state_ff.rld;
                        set_tf  = 1'b1;
                        tog_exf = updown;
                    end else begin
                        nxt_state.cnt = state_ff.cnt + `UDT_CNT_STEP;
                    end
                end
                default: begin
                    nxt_state.cnt = state_ff.cnt;
                end
            endcase
        end

        // falling edge on the direction pin with its enable: capture or forced reload
        if (ext_evt) begin
            set_exf = 1'b1;
            if (mode_sel == udt_pkg::UDT_MODE_CAPTURE) begin
                nxt_state.rld = state_ff.cnt;
            end else if (mode_sel == udt_pkg::UDT_MODE_RELOAD) begin
                nxt_state.cnt = state_ff.rld;
            end
        end

        // software writes take effect at the access cycle; they win over counting
        if (wr_en) begin
            case (PADDR)
                `UDT_OFS_CTRL:    nxt_state.ctrl = PWDATA[7:0];
                `UDT_OFS_MODE:    nxt_state.mode = PWDATA[1:0];
                `UDT_OFS_CNT_LO:  nxt_state.cnt[7:0] = PWDATA[7:0];
                `UDT_OFS_CNT_HI:  nxt_state.cnt[15:8] = PWDATA[7:0];
                `UDT_OFS_RLD_LO:  nxt_state.rld[7:0] = PWDATA[7:0];
                `UDT_OFS_RLD_HI:  nxt_state.rld[15:8] = PWDATA[7:0];
                `UDT_OFS_IRQ_ST:  nxt_state.irq_st = state_ff.irq_st & ~PWDATA[1:0];
                `UDT_OFS_IRQ_MSK: nxt_state.irq_mask = PWDATA[1:0];
                default:          nxt_state.irq_mask = state_ff.irq_mask;
            endcase
        end

        // hardware sets applied last so an event never loses to a clear
        if (set_tf) begin
            nxt_state.ctrl[`UDT_C_TF]  = 1'b1;
            nxt_state.irq_st[`UDT_I_OVF] = 1'b1;
        end
        if (set_exf) begin
            nxt_state.ctrl[`UDT_C_EXF]   = 1'b1;
            nxt_state.irq_st[`UDT_I_EXT] = 1'b1;
        end
        if (tog_exf) begin
            nxt_state.ctrl[`UDT_C_EXF] = ~nxt_state.ctrl[`UDT_C_EXF];
        end

        // read data is caught in the setup cycle so the answer comes from a flop
        if (PSEL && !PENABLE && !PWRITE) begin
            nxt_state.rdata = rd_word;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff          <= '0;
            state_ff.ctrl     <= `UDT_RST_CTRL;
            state_ff.mode     <= `UDT_RST_MODE;
            state_ff.cnt      <= `UDT_RST_WORD;
            state_ff.rld      <= `UDT_RST_WORD;
            state_ff.irq_st   <= `UDT_RST_IRQ;
            state_ff.irq_mask <= `UDT_RST_IRQ;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign PRDATA          = state_ff.rdata;
    assign PREADY          = PSEL && PENABLE;
    assign PSLVERR         = PSEL && PENABLE && !addr_hit;
    assign CLKOUT_PIN_O    = state_ff.clk_out;
    assign CLKOUT_PIN_OE_B = ~state_ff.mode[`UDT_M_OE];
    assign BAUD_TICK       = state_ff.baud;
    assign IRQ             = |(state_ff.irq_st & state_ff.irq_mask);

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    sequence s_run_12;
        (tick12 && run) ##1 run [*8] ##1 run [*3];
    endsequence

    sequence s_up_wrap;
        tick && updown && dir_up && cnt_full && !wr_cnt && !wr_ctrl;
    endsequence

    a_timer_div_12: assert property (s_run_12 |=> tick12)
        else $error("timer tick period is not 12 clocks");

    a_fast_div_2: assert property ((tick2 && run) ##1 run |=> tick2)
        else $error("fast tick period is not 2 clocks");

    a_stop_holds: assert property (!run && !wr_cnt && !ext_evt |=> $stable(state_ff.cnt))
        else $error("count moved while stopped");

    a_up_wrap_reload: assert property (s_up_wrap
                                       |=> state_ff.cnt == $past(state_ff.rld)
                                       && state_ff.ctrl[`UDT_C_TF])
        else $error("up overflow did not reload and flag");

    a_exf_toggles: assert property (s_up_wrap
                                    |=> state_ff.ctrl[`UDT_C_EXF]
                                    != $past(state_ff.ctrl[`UDT_C_EXF]))
        else $error("external flag did not toggle on wrap");

    a_down_underflow: assert property (tick && updown && !dir_up && !wr_cnt
                                       && state_ff.cnt == state_ff.rld
                                       |=> state_ff.cnt == `UDT_CNT_FULL)
        else $error("underflow did not load full count");

    a_down_step: assert property (tick && updown && !dir_up && !wr_cnt
                                  && state_ff.cnt != state_ff.rld
                                  |=> state_ff.cnt == $past(state_ff.cnt) - `UDT_CNT_STEP)
        else $error("down count step wrong");

    a_clkout_wrap: assert property (tick && cnt_full
                                    && mode_sel == udt_pkg::UDT_MODE_CLKOUT
                                    && !wr_irq && !wr_cnt
                                    |=> $changed(CLKOUT_PIN_O) && $stable(state_ff.irq_st)
                                    && state_ff.cnt == $past(state_ff.rld))
        else $error("clock-out wrap wrong or raised interrupt");

    a_ext_count: assert property (run && !fast && state_ff.ctrl[`UDT_C_SRC] && ext_fall
                                  && mode_sel == udt_pkg::UDT_MODE_CAPTURE
                                  && !wr_cnt && !ext_evt
                                  |=> state_ff.cnt == $past(state_ff.cnt) + `UDT_CNT_STEP)
        else $error("external falling edge not counted");

    a_pin_toggle_only: assert property (!(tick && fast && cnt_full)
                                        |=> $stable(CLKOUT_PIN_O))
        else $error("clock output moved without an overflow");

    a_stop_no_tick: assert property (!run |=> !tick12 && !tick2)
        else $error("prescaler ticked while stopped");

    a_ext_irq_quiet: assert property (tick && updown && !wr_irq
                                      |=> $stable(state_ff.irq_st[`UDT_I_EXT]))
        else $error("up/down wrap raised an external interrupt");

    // the pin follows baud overflows only while its output is enabled
    sequence s_baud_wrap;
        tick && mode_sel == udt_pkg::UDT_MODE_BAUD && cnt_full;
    endsequence

    a_baud_pulse: assert property (s_baud_wrap |=> BAUD_TICK)
        else $error("baud overflow gave no tick");

    a_baud_clkout: assert property (s_baud_wrap ##0 state_ff.mode[`UDT_M_OE]
                                    |=> $changed(CLKOUT_PIN_O))
        else $error("clock output ignored a baud overflow");

    a_ext_reload: assert property (ext_evt && mode_sel == udt_pkg::UDT_MODE_RELOAD
                                   && !wr_cnt && !wr_ctrl && !wr_irq
                                   |=> state_ff.cnt == $past(state_ff.rld)
                                   && state_ff.ctrl[`UDT_C_EXF] && state_ff.irq_st[`UDT_I_EXT])
        else $error("direction pin edge did not reload and flag");

endmodule // udt_timer
